/* logic/fuse_or_spi_calibration_select.sv */
// Calibration source selection between fused and serially written values for four cores and the master bank.
`timescale 1ns/1ps
module fuse_or_spi_calibration_select #(
	parameter int W = cal_sel_pkg::CAL_W,
	parameter int NC = cal_sel_pkg::NUM_CORES,
	parameter int NCAL = cal_sel_pkg::NUM_CORE_CAL
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic [NC*W-1:0] fuse_phase_in,
	input wire logic [NC*W-1:0] fuse_int_gain_in,
	input wire logic [NC*W-1:0] fuse_gain_in,
	input wire logic [NC*NCAL*W-1:0] fuse_core_calibration_words_in,
	input wire logic [NC*W-1:0] fuse_offset_in,
	input wire logic [W-1:0] fuse_impedance_trim_in,
	input wire logic [W-1:0] fuse_input_common_mode_trim_in,
	output logic [NC*W-1:0] phase_out,
	output logic [NC*W-1:0] int_gain_out,
	output logic [NC*W-1:0] gain_out,
	output logic [NC*NCAL*W-1:0] core_calibration_words_out,
	output logic [NC*W-1:0] offset_out,
	output logic [W-1:0] impedance_trim_out,
	output logic [W-1:0] input_common_mode_trim_out
);

	// ----------------------------------------
	// Target decoding
	// ----------------------------------------
	// Bit 4 of the mask is the master bank, bits 3..0 are cores D..A.
	function automatic logic [4:0] target_mask(input logic [15:0] sel);
		case (sel)
			cal_sel_pkg::SEL_CORE_A: target_mask = 5'h01;
			cal_sel_pkg::SEL_CORE_B: target_mask = 5'h02;
			cal_sel_pkg::SEL_CORE_C: target_mask = 5'h04;
			cal_sel_pkg::SEL_CORE_D: target_mask = 5'h08;
			cal_sel_pkg::SEL_ALL: target_mask = 5'h1f;
			cal_sel_pkg::SEL_MASTER: target_mask = 5'h10;
			default: target_mask = 5'h00;
		endcase
	endfunction

	logic [15:0] chan_sel_ff;
	logic [4:0] tgt;
	logic data_wr;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			chan_sel_ff <= cal_sel_pkg::CHAN_SEL_RESET;
		end else if (reg_wr_in && reg_addr_in == cal_sel_pkg::ADDR_CHAN_SEL) begin
			chan_sel_ff <= reg_wdata_in;
		end
	end

	assign tgt = target_mask(chan_sel_ff);
	assign data_wr = reg_wr_in && reg_addr_in != cal_sel_pkg::ADDR_CHAN_SEL;

	// ----------------------------------------
	// Core banks
	// ----------------------------------------
	logic [15:0] bank_src [NC];
	logic [W-1:0] bank_phase [NC];
	logic [W-1:0] bank_int_gain [NC];
	logic [W-1:0] bank_gain [NC];
	logic [NCAL*W-1:0] bank_core_cal [NC];
	logic bank_rd_hit [NC];
	logic [15:0] bank_rd_data [NC];

	for (genvar c = 0; c < NC; c++) begin : g_bank
		cal_channel_bank #(
			.W(W),
			.NCAL(NCAL)
		) u_bank (
			.core_clk_in(core_clk_in),
			.rst_in(rst_in),
			.wr_in(data_wr && tgt[c]),
			.addr_in(reg_addr_in),
			.wdata_in(reg_wdata_in),
			.fuse_phase_in(fuse_phase_in[c*W +: W]),
			.fuse_int_gain_in(fuse_int_gain_in[c*W +: W]),
			.fuse_gain_in(fuse_gain_in[c*W +: W]),
			.fuse_core_cal_in(fuse_core_calibration_words_in[c*NCAL*W +: NCAL*W]),
			.src_sel_out(bank_src[c]),
			.phase_out(bank_phase[c]),
			.int_gain_out(bank_int_gain[c]),
			.gain_out(bank_gain[c]),
			.core_cal_out(bank_core_cal[c]),
			.rd_hit_out(bank_rd_hit[c]),
			.rd_data_out(bank_rd_data[c])
		);
	end

	// ----------------------------------------
	// Master bank
	// ----------------------------------------
	logic master_wr;
	logic [15:0] master_src_ff;
	logic [W-1:0] offset_reg_ff [NC];
	logic [W-1:0] imp_reg_ff;
	logic [W-1:0] cm_reg_ff;

	assign master_wr = data_wr && tgt[cal_sel_pkg::MASTER_BANK];

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			master_src_ff <= cal_sel_pkg::SRC_SEL_RESET;
		end else if (master_wr && reg_addr_in == cal_sel_pkg::ADDR_SRC_SEL) begin
			master_src_ff <= reg_wdata_in & cal_sel_pkg::MASTER_SRC_MASK;
		end
	end

	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < NC; i++) begin
			if (rst_in) begin
				offset_reg_ff[i] <= W'(cal_sel_pkg::CAL_RESET);
			end else if (master_wr && reg_addr_in == 8'(cal_sel_pkg::ADDR_OFFSET0 + i)) begin
				offset_reg_ff[i] <= reg_wdata_in[W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			imp_reg_ff <= W'(cal_sel_pkg::CAL_RESET);
			cm_reg_ff <= W'(cal_sel_pkg::CAL_RESET);
		end else if (master_wr) begin
			if (reg_addr_in == cal_sel_pkg::ADDR_IMP) begin
				imp_reg_ff <= reg_wdata_in[W-1:0];
			end
			if (reg_addr_in == cal_sel_pkg::ADDR_CM) begin
				cm_reg_ff <= reg_wdata_in[W-1:0];
			end
		end
	end

	logic [W-1:0] offset_app [NC];
	logic [W-1:0] imp_app;
	logic [W-1:0] cm_app;

	always_comb begin
		for (int i = 0; i < NC; i++) begin
			offset_app[i] = master_src_ff[cal_sel_pkg::OFFSET_SOURCE_BIT] ?
				offset_reg_ff[i] : fuse_offset_in[i*W +: W];
		end
	end

	assign imp_app = master_src_ff[cal_sel_pkg::IMP_SOURCE_BIT] ? imp_reg_ff : fuse_impedance_trim_in;
	assign cm_app = master_src_ff[cal_sel_pkg::COMMON_MODE_SOURCE_BIT] ?
		cm_reg_ff : fuse_input_common_mode_trim_in;

	// ----------------------------------------
	// Registered converter outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		for (int c = 0; c < NC; c++) begin
			if (rst_in) begin
				phase_out[c*W +: W] <= fuse_phase_in[c*W +: W];
				int_gain_out[c*W +: W] <= fuse_int_gain_in[c*W +: W];
				gain_out[c*W +: W] <= fuse_gain_in[c*W +: W];
				core_calibration_words_out[c*NCAL*W +: NCAL*W] <= fuse_core_calibration_words_in[c*NCAL*W +: NCAL*W];
				offset_out[c*W +: W] <= fuse_offset_in[c*W +: W];
			end else begin
				phase_out[c*W +: W] <= bank_phase[c];
				int_gain_out[c*W +: W] <= bank_int_gain[c];
				gain_out[c*W +: W] <= bank_gain[c];
				core_calibration_words_out[c*NCAL*W +: NCAL*W] <= bank_core_cal[c];
				offset_out[c*W +: W] <= offset_app[c];
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			impedance_trim_out <= fuse_impedance_trim_in;
			input_common_mode_trim_out <= fuse_input_common_mode_trim_in;
		end else begin
			impedance_trim_out <= imp_app;
			input_common_mode_trim_out <= cm_app;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// A broadcast selection reads back core A; the master bank has no read path.
	logic [15:0] nxt_rdata;
	logic [15:0] rdata_ff;
	logic rvalid_ff;
	logic [1:0] rd_core;
	logic rd_core_ok;

	always_comb begin
		rd_core = 2'd0;
		rd_core_ok = 1'b0;
		for (int c = 0; c < NC; c++) begin
			if (tgt[c] && !rd_core_ok) begin
				rd_core = 2'(c);
				rd_core_ok = 1'b1;
			end
		end
		if (tgt[cal_sel_pkg::MASTER_BANK] && tgt[0] == 1'b0) begin
			rd_core_ok = 1'b0;
		end
	end

	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_addr_in == cal_sel_pkg::ADDR_CHAN_SEL) begin
			nxt_rdata = chan_sel_ff;
		end else if (rd_core_ok) begin
			if (bank_rd_hit[rd_core]) begin
				nxt_rdata = bank_rd_data[rd_core];
			end else if (reg_addr_in == cal_sel_pkg::ADDR_RO_IMP) begin
				nxt_rdata[W-1:0] = imp_app;
			end else if (reg_addr_in == cal_sel_pkg::ADDR_RO_CM) begin
				nxt_rdata[W-1:0] = cm_app;
			end else begin
				for (int i = 0; i < NC; i++) begin
					if (reg_addr_in == 8'(cal_sel_pkg::ADDR_RO_OFFSET0 + i)) begin
						nxt_rdata[W-1:0] = offset_app[i];
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd_in;
			if (reg_rd_in) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign reg_rvalid_out = rvalid_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	logic src_wr;
	assign src_wr = reg_wr_in && reg_addr_in == cal_sel_pkg::ADDR_SRC_SEL;

	chk_src_reset_zero: assert property ($fell(rst_in) |-> master_src_ff == 16'h0000 &&
		bank_src[0] == 16'h0000 && bank_src[1] == 16'h0000 && bank_src[2] == 16'h0000 && bank_src[3] == 16'h0000)
		else $error("source select not zero after reset");
	chk_fixed_zero_bits: assert property (bank_src[0][9] == 1'b0 && bank_src[0][5] == 1'b0 &&
		bank_src[3][9] == 1'b0 && bank_src[3][5] == 1'b0)
		else $error("fixed source select bits not zero");
	chk_single_target: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_CORE_B |=>
		bank_src[1] == ($past(reg_wdata_in) & 16'h01d0) && $stable(bank_src[0]) && $stable(bank_src[2]) &&
		$stable(bank_src[3]) && $stable(master_src_ff))
		else $error("single channel write reached other banks");
	chk_broadcast_write: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_ALL |=>
		bank_src[0] == ($past(reg_wdata_in) & 16'h01d0) && bank_src[3] == ($past(reg_wdata_in) & 16'h01d0) &&
		master_src_ff == ($past(reg_wdata_in) & 16'h0007))
		else $error("broadcast write missed a bank");
	chk_broadcast_0014: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_ALL &&
		reg_wdata_in == 16'h0014 |=> bank_src[2] == 16'h0010 && master_src_ff == 16'h0004)
		else $error("broadcast 0014 did not set phase and impedance bits");
	chk_master_0005: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_MASTER &&
		reg_wdata_in == 16'h0005 |=> master_src_ff == 16'h0005 && $stable(bank_src[0]) ##1
		impedance_trim_out == $past(imp_reg_ff) && offset_out[W-1:0] == $past(offset_reg_ff[0]))
		else $error("master 0005 did not switch offsets and impedance");
	chk_invalid_sel_ignored: assert property (src_wr && tgt == 5'h00 |=> $stable(master_src_ff) &&
		$stable(bank_src[0]) && $stable(bank_src[1]) && $stable(bank_src[2]) && $stable(bank_src[3]))
		else $error("write under undocumented selector changed a bank");
	chk_master_no_read: assert property (reg_rd_in && chan_sel_ff == cal_sel_pkg::SEL_MASTER &&
		reg_addr_in != cal_sel_pkg::ADDR_CHAN_SEL |=> reg_rvalid_out && reg_rdata_out == 16'h0000)
		else $error("master bank returned read data");
	chk_ro_applied: assert property (reg_rd_in && chan_sel_ff == cal_sel_pkg::SEL_CORE_C &&
		reg_addr_in == cal_sel_pkg::ADDR_RO_PHASE |=> reg_rdata_out[W-1:0] == $past(bank_phase[2]))
		else $error("read-only address did not return applied value");
	chk_phase_only_there: assert property (reg_wr_in && reg_addr_in == cal_sel_pkg::ADDR_PHASE &&
		chan_sel_ff == cal_sel_pkg::SEL_CORE_A && bank_src[0][4] |=> bank_phase[0] == $past(reg_wdata_in[W-1:0])
		&& $stable(bank_phase[1]) ##1 phase_out[W-1:0] == $past(bank_phase[0]))
		else $error("phase write not applied only to selected channel");
	chk_core_d_target: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_CORE_D |=>
		bank_src[3] == ($past(reg_wdata_in) & cal_sel_pkg::CHAN_SRC_MASK) && $stable(bank_src[0]) &&
		$stable(master_src_ff))
		else $error("core D write not routed to core D alone");
	chk_master_only: assert property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_MASTER |=>
		master_src_ff == ($past(reg_wdata_in) & cal_sel_pkg::MASTER_SRC_MASK) && $stable(bank_src[0]) &&
		$stable(bank_src[3]))
		else $error("master write reached a core bank");
	chk_cm_serial: assert property ($past(master_src_ff[cal_sel_pkg::COMMON_MODE_SOURCE_BIT]) |->
		input_common_mode_trim_out == $past(cm_reg_ff))
		else $error("common mode trim not taken from serial register");
	chk_offset_fused: assert property (!$past(master_src_ff[cal_sel_pkg::OFFSET_SOURCE_BIT]) |->
		offset_out[W-1:0] == $past(fuse_offset_in[W-1:0]))
		else $error("offset trim not taken from fuses");
	chk_imp_serial: assert property ($past(master_src_ff[cal_sel_pkg::IMP_SOURCE_BIT]) |->
		impedance_trim_out == $past(imp_reg_ff))
		else $error("impedance trim not taken from serial register");
	chk_undoc_no_read: assert property (reg_rd_in && tgt == 5'h00 &&
		reg_addr_in != cal_sel_pkg::ADDR_CHAN_SEL |=> reg_rdata_out == 16'h0000)
		else $error("read under undocumented selector returned data");
	chk_bcast_read_a: assert property (reg_rd_in && chan_sel_ff == cal_sel_pkg::SEL_ALL && bank_rd_hit[0] |=>
		reg_rdata_out == $past(bank_rd_data[0]))
		else $error("broadcast read not served by core A");
	chk_core_cal_fused: assert property (!$past(bank_src[2][cal_sel_pkg::CORE_CAL_SOURCE_BIT]) |->
		core_calibration_words_out[2*NCAL*W +: W] == $past(fuse_core_calibration_words_in[2*NCAL*W +: W]))
		else $error("core C calibration word not taken from fuses");
	chk_ro_imp_read: assert property (reg_rd_in && chan_sel_ff == cal_sel_pkg::SEL_CORE_B &&
		reg_addr_in == cal_sel_pkg::ADDR_RO_IMP |=> reg_rdata_out[W-1:0] == $past(imp_app))
		else $error("read-only impedance address did not return applied value");

	cov_broadcast: cover property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_ALL);
	cov_master_write: cover property (src_wr && chan_sel_ff == cal_sel_pkg::SEL_MASTER);
	cov_phase_serial: cover property (reg_wr_in && reg_addr_in == cal_sel_pkg::ADDR_PHASE && bank_src[1][4]);
	cov_ro_read: cover property (reg_rd_in && reg_addr_in == cal_sel_pkg::ADDR_RO_PHASE);
	cov_invalid_sel: cover property (src_wr && tgt == 5'h00);

endmodule // fuse_or_spi_calibration_select

/* logic/cal_sel_pkg.sv */
// Shared constants for the fused-or-serial calibration source selection block.
package cal_sel_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int CAL_W = 16;
	localparam int NUM_CORES = 4;
	localparam int NUM_CORE_CAL = 7;
	localparam int NUM_BANKS = 5;
	localparam int MASTER_BANK = 4;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CHAN_SEL = 8'h0f;
	localparam logic [7:0] ADDR_SRC_SEL = 8'h16;
	localparam logic [7:0] ADDR_PHASE = 8'h20;
	localparam logic [7:0] ADDR_INT_GAIN = 8'h21;
	localparam logic [7:0] ADDR_GAIN = 8'h22;
	localparam logic [7:0] ADDR_CORE_CAL0 = 8'h23;
	localparam logic [7:0] ADDR_RO_PHASE = 8'h30;
	localparam logic [7:0] ADDR_RO_INT_GAIN = 8'h31;
	localparam logic [7:0] ADDR_RO_GAIN = 8'h32;
	localparam logic [7:0] ADDR_RO_CORE_CAL0 = 8'h33;
	localparam logic [7:0] ADDR_OFFSET0 = 8'h40;
	localparam logic [7:0] ADDR_IMP = 8'h44;
	localparam logic [7:0] ADDR_CM = 8'h45;
	localparam logic [7:0] ADDR_RO_OFFSET0 = 8'h50;
	localparam logic [7:0] ADDR_RO_IMP = 8'h54;
	localparam logic [7:0] ADDR_RO_CM = 8'h55;

	// ----------------------------------------
	// Source-select fields
	// ----------------------------------------
	localparam int PHASE_SOURCE_BIT = 4;
	localparam int INT_GAIN_SOURCE_BIT = 6;
	localparam int GAIN_SOURCE_BIT = 7;
	localparam int CORE_CAL_SOURCE_BIT = 8;
	localparam int OFFSET_SOURCE_BIT = 0;
	localparam int COMMON_MODE_SOURCE_BIT = 1;
	localparam int IMP_SOURCE_BIT = 2;
	localparam logic [15:0] CHAN_SRC_MASK = 16'h01d0;
	localparam logic [15:0] MASTER_SRC_MASK = 16'h0007;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] SRC_SEL_RESET = 16'h0000;
	localparam logic [15:0] CAL_RESET = 16'h0000;
	localparam logic [15:0] CHAN_SEL_RESET = 16'h0000;

	// ----------------------------------------
	// Channel-target selector codes
	// ----------------------------------------
	localparam logic [15:0] SEL_CORE_A = 16'h0000;
	localparam logic [15:0] SEL_CORE_B = 16'h0001;
	localparam logic [15:0] SEL_CORE_C = 16'h0002;
	localparam logic [15:0] SEL_CORE_D = 16'h0003;
	localparam logic [15:0] SEL_ALL = 16'h0004;
	localparam logic [15:0] SEL_MASTER = 16'h0007;

endpackage

/* logic/cal_channel_bank.sv */
// One converter core's serial calibration registers and fuse/serial selection.
`timescale 1ns/1ps
module cal_channel_bank #(
	parameter int W = 16,
	parameter int NCAL = 7
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic wr_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [W-1:0] fuse_phase_in,
	input wire logic [W-1:0] fuse_int_gain_in,
	input wire logic [W-1:0] fuse_gain_in,
	input wire logic [NCAL*W-1:0] fuse_core_cal_in,
	output logic [15:0] src_sel_out,
	output logic [W-1:0] phase_out,
	output logic [W-1:0] int_gain_out,
	output logic [W-1:0] gain_out,
	output logic [NCAL*W-1:0] core_cal_out,
	output logic rd_hit_out,
	output logic [15:0] rd_data_out
);

	logic [15:0] src_ff;
	logic [W-1:0] phase_ff;
	logic [W-1:0] int_gain_ff;
	logic [W-1:0] gain_ff;
	logic [W-1:0] core_cal_ff [NCAL];

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			src_ff <= cal_sel_pkg::SRC_SEL_RESET;
		end else if (wr_in && addr_in == cal_sel_pkg::ADDR_SRC_SEL) begin
			src_ff <= wdata_in & cal_sel_pkg::CHAN_SRC_MASK;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			phase_ff <= W'(cal_sel_pkg::CAL_RESET);
			int_gain_ff <= W'(cal_sel_pkg::CAL_RESET);
			gain_ff <= W'(cal_sel_pkg::CAL_RESET);
		end else if (wr_in) begin
			if (addr_in == cal_sel_pkg::ADDR_PHASE) begin
				phase_ff <= wdata_in[W-1:0];
			end
			if (addr_in == cal_sel_pkg::ADDR_INT_GAIN) begin
				int_gain_ff <= wdata_in[W-1:0];
			end
			if (addr_in == cal_sel_pkg::ADDR_GAIN) begin
				gain_ff <= wdata_in[W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < NCAL; i++) begin
			if (rst_in) begin
				core_cal_ff[i] <= W'(cal_sel_pkg::CAL_RESET);
			end else if (wr_in && addr_in == 8'(cal_sel_pkg::ADDR_CORE_CAL0 + i)) begin
				core_cal_ff[i] <= wdata_in[W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Value applied to the core
	// ----------------------------------------
	assign src_sel_out = src_ff;
	assign phase_out = src_ff[cal_sel_pkg::PHASE_SOURCE_BIT] ? phase_ff : fuse_phase_in;
	assign int_gain_out = src_ff[cal_sel_pkg::INT_GAIN_SOURCE_BIT] ? int_gain_ff : fuse_int_gain_in;
	assign gain_out = src_ff[cal_sel_pkg::GAIN_SOURCE_BIT] ? gain_ff : fuse_gain_in;

	always_comb begin
		for (int i = 0; i < NCAL; i++) begin
			core_cal_out[i*W +: W] = src_ff[cal_sel_pkg::CORE_CAL_SOURCE_BIT] ?
				core_cal_ff[i] : fuse_core_cal_in[i*W +: W];
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	always_comb begin
		rd_hit_out = 1'b1;
		rd_data_out = 16'h0000;
		case (addr_in)
			cal_sel_pkg::ADDR_SRC_SEL: rd_data_out = src_ff;
			cal_sel_pkg::ADDR_PHASE: rd_data_out[W-1:0] = phase_ff;
			cal_sel_pkg::ADDR_INT_GAIN: rd_data_out[W-1:0] = int_gain_ff;
			cal_sel_pkg::ADDR_GAIN: rd_data_out[W-1:0] = gain_ff;
			cal_sel_pkg::ADDR_RO_PHASE: rd_data_out[W-1:0] = phase_out;
			cal_sel_pkg::ADDR_RO_INT_GAIN: rd_data_out[W-1:0] = int_gain_out;
			cal_sel_pkg::ADDR_RO_GAIN: rd_data_out[W-1:0] = gain_out;
			default: begin
				rd_hit_out = 1'b0;
				for (int i = 0; i < NCAL; i++) begin
					if (addr_in == 8'(cal_sel_pkg::ADDR_CORE_CAL0 + i)) begin
						rd_hit_out = 1'b1;
						rd_data_out[W-1:0] = core_cal_ff[i];
					end
					if (addr_in == 8'(cal_sel_pkg::ADDR_RO_CORE_CAL0 + i)) begin
						rd_hit_out = 1'b1;
						rd_data_out[W-1:0] = core_cal_out[i*W +: W];
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	chk_phase_fused: assert property (!src_ff[4] |-> phase_out == fuse_phase_in)
		else $error("phase trim not taken from fuses");
	chk_int_gain_src: assert property (src_ff[6] && wr_in && addr_in == cal_sel_pkg::ADDR_INT_GAIN
		|=> int_gain_out == $past(wdata_in[W-1:0]))
		else $error("internal gain not taken from serial register");
	chk_gain_fused: assert property (!src_ff[7] |-> gain_out == fuse_gain_in)
		else $error("interleave gain not taken from fuses");
	chk_core_cal_group: assert property (src_ff[8] && wr_in && addr_in == cal_sel_pkg::ADDR_CORE_CAL0
		|=> core_cal_out[W-1:0] == $past(wdata_in[W-1:0]))
		else $error("core calibration word not taken from serial register");
	chk_phase_write_now: assert property (src_ff[4] && wr_in && addr_in == cal_sel_pkg::ADDR_PHASE
		|=> phase_out == $past(wdata_in[W-1:0]))
		else $error("phase trim write not applied at once");

endmodule // cal_channel_bank

/* testbench/cal_host.sv */
// Register host model driving the calibration block's write and read strobes.
`timescale 1ns/1ps
module cal_host (
	input wire logic core_clk_in,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 16'h0000;
	end
	// A released bus shows the inverse of its last value so stale data never looks valid.
	task automatic put(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		wr_out <= w;
		rd_out <= !w;
		addr_out <= a;
		wdata_out <= d;
		@(posedge core_clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		put(1'b1, a, d);
	endtask
	task automatic read(input logic [7:0] a, output logic [15:0] d, output bit ok);
		put(1'b0, a, 16'h0000);
		ok = 0;
		for (int n = 0; n < 4 && !ok; n++) begin
			#1;
			ok = (rvalid_in === 1'b1);
			d = rdata_in;
			if (!ok) @(posedge core_clk_in);
		end
	endtask
endmodule // cal_host

/* testbench/tb.sv */
// Self-checking bench for the fuse or serial calibration source selection block.
`timescale 1ns/1ps
module tb;
	logic core_clk_in, rst_in, host_wr, rd, rvalid;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, f_imp, f_cm, o_imp, o_cm;
	logic [63:0] f_ph, f_ig, f_g, f_off, o_ph, o_ig, o_g, o_off;
	logic [447:0] f_cal, o_cal;
	logic [15:0] fz[5][10], ser[5][10], src[5];
	int sel, n_errors, n_compared;

	cal_host u_cal_host (.core_clk_in(core_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(host_wr),
		.rd_out(rd), .addr_out(addr), .wdata_out(wdata));
	fuse_or_spi_calibration_select u_fuse_or_spi_calibration_select (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.reg_wr_in(host_wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .fuse_phase_in(f_ph), .fuse_int_gain_in(f_ig), .fuse_gain_in(f_g),
		.fuse_core_calibration_words_in(f_cal), .fuse_offset_in(f_off), .fuse_impedance_trim_in(f_imp),
		.fuse_input_common_mode_trim_in(f_cm), .phase_out(o_ph), .int_gain_out(o_ig), .gain_out(o_g),
		.core_calibration_words_out(o_cal), .offset_out(o_off), .impedance_trim_out(o_imp),
		.input_common_mode_trim_out(o_cm));

	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] app(int c, int k);
		int b;
		if (c == 4) b = (k < 4) ? 0 : (k == 4) ? 2 : 1;
		else b = (k == 0) ? 4 : (k == 1) ? 6 : (k == 2) ? 7 : 8;
		return src[c][b] ? ser[c][k] : fz[c][k];
	endfunction
	function automatic logic [15:0] outv(int c, int k);
		if (c == 4) return (k < 4) ? o_off[k*16+:16] : (k == 4) ? o_imp : o_cm;
		if (k < 3) return k == 0 ? o_ph[c*16+:16] : k == 1 ? o_ig[c*16+:16] : o_g[c*16+:16];
		return o_cal[(c*7+k-3)*16+:16];
	endfunction
	function automatic logic [15:0] rexp(logic [7:0] a);
		int c;
		c = (sel == 4) ? 0 : sel;
		if (c > 3) return 16'h0000;
		if (a == 8'h16) return src[c];
		if (a >= 8'h20 && a <= 8'h29) return ser[c][a-8'h20];
		if (a >= 8'h30 && a <= 8'h39) return app(c, a - 8'h30);
		if (a >= 8'h50 && a <= 8'h55) return app(4, a - 8'h50);
		return 16'h0000;
	endfunction
	// The model routes each write to the banks the selector designates, then mirrors the design.
	task automatic wr(logic [7:0] a, logic [15:0] d);
		u_cal_host.write(a, d);
		if (a == cal_sel_pkg::ADDR_CHAN_SEL) sel = d;
		else for (int c = 0; c < 5; c++) begin
			if ((sel == c && c < 4) || sel == 4 || (sel == 7 && c == 4)) begin
				if (a == cal_sel_pkg::ADDR_SRC_SEL) src[c] = d & (c == 4 ? 16'h0007 : 16'h01d0);
				else if (c < 4 && a >= 8'h20 && a <= 8'h29) ser[c][a-8'h20] = d;
				else if (c == 4 && a >= 8'h40 && a <= 8'h45) ser[4][a-8'h40] = d;
			end
		end
	endtask
	task automatic rdchk(logic [7:0] a);
		logic [15:0] d, e;
		bit ok;
		e = rexp(a);
		u_cal_host.read(a, d, ok);
		if (!ok) begin
			n_errors++;
			$display("mismatch at %0t: no read answer", $time);
			test_done();
		end
		chk(d, e);
	endtask
	task automatic check_all();
		repeat (2) @(posedge core_clk_in);
		#1;
		for (int c = 0; c < 5; c++)
			for (int k = 0; k < (c == 4 ? 6 : 10); k++)
				chk(outv(c, k), app(c, k));
	endtask

	initial begin
		repeat (100000) @(posedge core_clk_in);
		n_errors++;
		$display("mismatch at %0t: run too long", $time);
		test_done();
	end

	initial begin
		void'($urandom(32'h142d));
		sel = 0;
		for (int c = 0; c < 5; c++) begin
			src[c] = 16'h0000;
			for (int k = 0; k < 10; k++) begin
				fz[c][k] = 16'($urandom);
				ser[c][k] = 16'h0000;
			end
		end
		for (int c = 0; c < 4; c++) begin
			f_ph[c*16+:16] = fz[c][0];
			f_ig[c*16+:16] = fz[c][1];
			f_g[c*16+:16] = fz[c][2];
			f_off[c*16+:16] = fz[4][c];
			for (int k = 0; k < 7; k++)
				f_cal[(c*7+k)*16+:16] = fz[c][k+3];
		end
		f_imp = fz[4][4];
		f_cm = fz[4][5];
		rst_in = 1'b1;
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		check_all();
		rdchk(8'h16);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h0f, 16'(c));
			for (int k = 0; k < 10; k++)
				wr(8'h20 + 8'(k), 16'($urandom));
			rdchk(8'h20);
			rdchk(8'h30);
			wr(8'h16, 16'h03f0);
			rdchk(8'h16);
			for (int k = 0; k < 4; k++)
				wr(8'h20 + 8'(k), 16'($urandom));
			check_all();
			rdchk(8'h30);
		end
		$display("test single channel done");
		wr(8'h0f, 16'h0007);
		wr(8'h16, 16'h0005);
		for (int k = 0; k < 6; k++)
			wr(8'h40 + 8'(k), 16'($urandom));
		check_all();
		rdchk(8'h16);
		wr(8'h16, 16'h0002);
		check_all();
		wr(8'h0f, 16'h0001);
		rdchk(8'h54);
		rdchk(8'h55);
		$display("test master done");
		for (int i = 5; i < 9; i++) begin
			wr(8'h0f, 16'(i));
			wr(8'h16, 16'h0000);
			wr(8'h20, 16'($urandom));
			rdchk(8'h16);
		end
		check_all();
		$display("test invalid selector done");
		wr(8'h0f, 16'h0004);
		wr(8'h16, 16'h0000);
		check_all();
		wr(8'h16, 16'h0014);
		check_all();
		for (int c = 0; c < 4; c++) begin
			wr(8'h0f, 16'(c));
			wr(8'h20, 16'($urandom));
		end
		check_all();
		wr(8'h0f, 16'h0004);
		wr(8'h16, 16'h01d7);
		check_all();
		rdchk(8'h39);
		$display("test broadcast done");
		test_done();
	end
endmodule // tb
